/* rtl/ctd_top.sv */
// Camera input pin configuration and trigger delay ahead of integration start.
// Assumes pin and trigger-mode inputs synchronous to clk; host drives reg_req.
//
// Overview of operation
// - Bit 7 of input config inverts the input pin, 1 meaning inverted.
// - Routing bits 11..15: 0x00 input off, 0x02 trigger (default), others reserved.
// - Input config bit 31 reads back the current pin level.
// - A shared-pin flag reports output and input sharing one connector pin.
// - Standard delay value in control bits 20..31, times the timebase.
// - Capability register reports presence, absolute, readout, on/off, manual; one-push and auto bits read 0.
// - Capability bits 8..19 hold minimum delay, bits 20..31 the maximum.
// - Control bit 0 reads 1 since the delay function is present.
// - Control bit 1 picks absolute-value delay instead of the value field.
// - Control bit 6 switches the standard delay on or off and reads back.
// - Fine delay register: presence bit 0, enable bit 6, microseconds in 11..31.
// - Enabled fine delay postpones integration start by programmed microseconds.
// - Fine delay acts only in external edge trigger mode 0.
// - Capture starts on trigger only when external triggering is selected.
`timescale 1ns/10ps
`include "ctd_cfg.svh"

module ctd_top
  import ctd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  input  wire ctd_req_t    reg_req,
  input  wire logic        gp_in_pin,
  input  wire logic        ext_trig_en,
  input  wire logic [3:0]  trigger_mode,
  input  wire logic [21:0] abs_delay_us,
  output logic [31:0]      reg_rdata_q,
  output logic             reg_ack_q,
  output logic             shared_pin_flag_q,
  output logic             delay_busy_q,
  output logic             integration_start_q
);

  // Exact word match on a register address
  function automatic logic hit(input logic [31:0] a, input logic [31:0] off);
    hit = (a == off);
  endfunction

  logic [31:0] cap_word;
  logic        pin_q;
  logic        trig_prev_q;
  logic        pol_q;
  logic [4:0]  route_q;
  logic        abs_sel_q;
  logic        std_on_q;
  logic [11:0] std_val_q;
  logic        fine_on_q;
  logic [20:0] fine_us_q;
  ctd_state_t  state_q;
  logic [21:0] cnt_q;
  logic [4:0]  presc_q;
  logic        trig_lvl;
  logic        trig_edge;
  logic        fine_act;
  logic [21:0] std_delay;
  logic        wr_ctl;
  logic        wr_inp;
  logic        wr_fine;

  // Fixed capability word, read only
  assign cap_word = {`CTD_MAX_VALUE, `CTD_MIN_VALUE, `CTD_CAP_FLAGS};

  assign wr_ctl  = reg_req.wr && hit(reg_req.addr, `CTD_CTL_ADDR);
  assign wr_inp  = reg_req.wr && hit(reg_req.addr, `CTD_INP_ADDR);
  assign wr_fine = reg_req.wr && hit(reg_req.addr, `CTD_FINE_ADDR);

  // Polarity applied before routing; reserved codes behave as off
  assign trig_lvl  = (route_q == `CTD_ROUTE_TRIG) && (pin_q ^ pol_q);
  assign trig_edge = trig_lvl && !trig_prev_q;
  assign fine_act  = fine_on_q && (trigger_mode == `CTD_EDGE_MODE);
  // Absolute source overrides the value field entirely
  assign std_delay = abs_sel_q ? abs_delay_us :
                     22'(std_val_q) * 22'(`CTD_TIMEBASE_US);

  // Pin sampling and edge history
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_q       <= 1'b0;
      trig_prev_q <= 1'b0;
    end else if (ce) begin
      pin_q       <= gp_in_pin;
      trig_prev_q <= trig_lvl;
    end
  end

  // Input configuration register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pol_q   <= `CTD_POL_RST;
      route_q <= `CTD_ROUTE_RST;
    end else if (ce && wr_inp) begin
      pol_q   <= reg_req.wdata[`CTD_POL_BIT];
      route_q <= reg_req.wdata[`CTD_ROUTE_MSB:`CTD_ROUTE_LSB];
    end
  end

  // Standard delay control register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      abs_sel_q <= 1'b0;
      std_on_q  <= 1'b0;
      std_val_q <= `CTD_VAL_RST;
    end else if (ce && wr_ctl) begin
      abs_sel_q <= reg_req.wdata[`CTD_ABS_BIT];
      std_on_q  <= reg_req.wdata[`CTD_ON_BIT];
      std_val_q <= reg_req.wdata[31:`CTD_VAL_LSB];
    end
  end

  // Fine delay register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fine_on_q <= 1'b0;
      fine_us_q <= `CTD_FINE_RST;
    end else if (ce && wr_fine) begin
      fine_on_q <= reg_req.wdata[`CTD_ON_BIT];
      fine_us_q <= reg_req.wdata[31:`CTD_FINE_LSB];
    end
  end

  // Read port: one-cycle answer, unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_q <= 32'h00000000;
      reg_ack_q   <= 1'b0;
    end else if (ce) begin
      reg_ack_q   <= reg_req.rd || reg_req.wr;
      reg_rdata_q <= 32'h00000000;
      if (reg_req.rd) begin
        if (hit(reg_req.addr, `CTD_CAP_ADDR)) begin
          reg_rdata_q <= cap_word;
        end else if (hit(reg_req.addr, `CTD_CTL_ADDR)) begin
          reg_rdata_q <= {std_val_q, 13'h0000, std_on_q, 4'h0, abs_sel_q, 1'b1};
        end else if (hit(reg_req.addr, `CTD_INP_ADDR)) begin
          reg_rdata_q <= {pin_q, 15'h0000, route_q, 3'h0, pol_q, 6'h00, 1'b1};
        end else if (hit(reg_req.addr, `CTD_FINE_ADDR)) begin
          reg_rdata_q <= {fine_us_q, 4'h0, fine_on_q, 5'h00, 1'b1};
        end
      end
    end
  end

  // Shared pin report; the host keeps output and input apart
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shared_pin_flag_q <= 1'b0;
    end else if (ce) begin
      shared_pin_flag_q <= `CTD_SHARED_PIN;
    end
  end

  // Delay sequencer; a new edge restarts any delay in progress
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q             <= CTD_IDLE;
      cnt_q               <= 22'h000000;
      presc_q             <= 5'h00;
      integration_start_q <= 1'b0;
      delay_busy_q        <= 1'b0;
    end else if (ce) begin
      integration_start_q <= 1'b0;
      if (trig_edge && ext_trig_en) begin
        presc_q <= 5'h00;
        if (fine_act) begin
          cnt_q        <= {1'b0, fine_us_q};
          state_q      <= CTD_WAIT;
          delay_busy_q <= 1'b1;
        end else if (std_on_q) begin
          cnt_q        <= std_delay;
          state_q      <= CTD_WAIT;
          delay_busy_q <= 1'b1;
        end else begin
          integration_start_q <= 1'b1;
          state_q             <= CTD_IDLE;
          delay_busy_q        <= 1'b0;
        end
      end else begin
        case (state_q)
          CTD_IDLE: begin
            delay_busy_q <= 1'b0;
          end
          CTD_WAIT: begin
            if (!ext_trig_en) begin
              // Leaving external mode drops a pending start
              state_q      <= CTD_IDLE;
              delay_busy_q <= 1'b0;
            end else if (cnt_q == 22'h000000) begin
              integration_start_q <= 1'b1;
              state_q             <= CTD_IDLE;
              delay_busy_q        <= 1'b0;
            end else if (presc_q == 5'(`CTD_TICK_CYCLES - 1)) begin
              presc_q <= 5'h00;
              cnt_q   <= cnt_q - 22'h000001;
            end else begin
              presc_q <= presc_q + 5'h01;
            end
          end
          default: begin
            state_q <= CTD_IDLE;
          end
        endcase
      end
    end
  end

  route_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && (route_q != `CTD_ROUTE_TRIG) && (state_q == CTD_IDLE)) |=> !integration_start_q)
    else $error("integration start with input not routed to trigger");

  pin_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && reg_req.rd && hit(reg_req.addr, `CTD_INP_ADDR)) |=> reg_rdata_q[31] == $past(pin_q))
    else $error("pin level readback wrong");

  cap_read_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && reg_req.rd && hit(reg_req.addr, `CTD_CAP_ADDR)) |=> reg_rdata_q == 32'hfff000b3)
    else $error("capability word wrong");

  ctl_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && wr_ctl) |=> std_val_q == $past(reg_req.wdata[31:20]))
    else $error("delay value not stored");

  on_readback_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && reg_req.rd && hit(reg_req.addr, `CTD_CTL_ADDR)) |=>
      (reg_rdata_q[6] == $past(std_on_q)) && reg_rdata_q[0])
    else $error("on/off or presence readback wrong");

  abs_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && trig_edge && ext_trig_en && !fine_act && std_on_q && abs_sel_q) |=>
      cnt_q == $past(abs_delay_us))
    else $error("absolute delay not loaded");

  fine_load_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && trig_edge && ext_trig_en && fine_act) |=>
      (cnt_q == {1'b0, $past(fine_us_q)}) && (state_q == CTD_WAIT))
    else $error("fine delay not loaded on edge");

  mode_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ce && trig_edge && ext_trig_en && (trigger_mode != 4'h0) && !std_on_q) |=>
      integration_start_q)
    else $error("fine delay acted outside mode 0");

  ext_only_a: assert property (@(posedge clk) disable iff (!rst_n)
    (integration_start_q && $past(ce)) |-> $past(ext_trig_en))
    else $error("start without external triggering");

  tick_span_a: assert property (@(posedge clk) disable iff (!rst_n)
    presc_q < 5'(`CTD_TICK_CYCLES))
    else $error("microsecond prescaler overran");

endmodule

/* rtl/ctd_cfg.svh */
// Constants for the camera trigger input and trigger delay block.
// Assumes a 20 MHz clock and 32-bit register words.
`ifndef CTD_CFG_SVH
`define CTD_CFG_SVH

// Register byte addresses
`define CTD_CAP_ADDR      32'hf0f00534
`define CTD_CTL_ADDR      32'hf0f00834
`define CTD_INP_ADDR      32'hf1000300
`define CTD_FINE_ADDR     32'hf1000400

// Field positions
`define CTD_PRESENCE_BIT  0
`define CTD_ABS_BIT       1
`define CTD_ONEPUSH_BIT   3
`define CTD_READOUT_BIT   4
`define CTD_ONOFF_CAP_BIT 5
`define CTD_AUTO_BIT      6
`define CTD_MANUAL_BIT    7
`define CTD_ON_BIT        6
`define CTD_POL_BIT       7
`define CTD_ROUTE_LSB     11
`define CTD_ROUTE_MSB     15
`define CTD_PIN_BIT       31
`define CTD_VAL_LSB       20
`define CTD_MIN_LSB       8
`define CTD_FINE_LSB      11

// Capability contents
`define CTD_CAP_FLAGS     8'hb3
`define CTD_MIN_VALUE     12'h000
`define CTD_MAX_VALUE     12'hfff

// Routing codes and reset values
`define CTD_ROUTE_OFF     5'h00
`define CTD_ROUTE_TRIG    5'h02
`define CTD_ROUTE_RST     5'h02
`define CTD_POL_RST       1'h0
`define CTD_VAL_RST       12'h000
`define CTD_FINE_RST      21'h000000
`define CTD_SHARED_PIN    1'h1
`define CTD_EDGE_MODE     4'h0

// Timing
`define CTD_CLK_PERIOD_NS 50
`define CTD_TICK_NS       1000
`define CTD_TICK_CYCLES   (`CTD_TICK_NS / `CTD_CLK_PERIOD_NS)
`define CTD_TIMEBASE_US   1

`endif

/* rtl/ctd_pkg.sv */
// Types for the camera trigger input and trigger delay block.
// Constants live in ctd_cfg.svh.
package ctd_pkg;

  typedef enum logic [0:0] {
    CTD_IDLE = 1'b0,
    CTD_WAIT = 1'b1
  } ctd_state_t;

  typedef struct packed {
    logic [31:0] addr;
    logic        wr;
    logic        rd;
    logic [31:0] wdata;
  } ctd_req_t;

endpackage

/* tb/ctd_trig_src.sv */
// Partner model: external trigger source on the camera input pin.
// Assumes the bench clock; fire is a one-cycle request taken at a rising edge.
`timescale 1ns/10ps
module ctd_trig_src (
  input  wire logic clk,
  input  wire logic fire,
  input  wire logic idle,
  output logic      pin
);
  logic [1:0] cnt_q = 2'h0;
  // Pulse three cycles, long enough to outlast the pin sampling flop
  always_ff @(posedge clk) begin
    if (fire) begin
      cnt_q <= 2'h3;
    end else if (cnt_q != 2'h0) begin
      cnt_q <= cnt_q - 2'h1;
    end
  end
  // Only the input side is driven; the output driver stays off
  assign pin = (cnt_q != 2'h0) ? ~idle : idle;
endmodule

/* tb/testbench.sv */
// Bench for the trigger input and delay block: registers and trigger latency.
// Assumes ctd_cfg.svh on the include path and ctd_pkg compiled first.
`timescale 1ns/10ps
`include "ctd_cfg.svh"
module testbench;
  import ctd_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  ctd_req_t    req = '0;
  logic        fire = 1'b0;
  logic        idle = 1'b0;
  logic        en = 1'b0;
  logic        ce = 1'b1;
  int          hold = 0;
  logic [3:0]  mode = 4'h0;
  logic [21:0] abs_us = 22'h0;
  logic        pin, ack, flag, busy, start;
  logic [31:0] rdata, r, w;
  int          err_count = 0;
  int          total_checks = 0;
  int          v;
  ctd_top dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_req(req), .gp_in_pin(pin),
    .ext_trig_en(en), .trigger_mode(mode), .abs_delay_us(abs_us), .reg_rdata_q(rdata),
    .reg_ack_q(ack), .shared_pin_flag_q(flag), .delay_busy_q(busy),
    .integration_start_q(start));
  ctd_trig_src src_u (.clk(clk), .fire(fire), .idle(idle), .pin(pin));
  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end
  task automatic finish_test;
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chkn(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One register access; a write never reads, so no old value comes back
  task automatic acc(input logic [31:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wr: wr, rd: ~wr, wdata: d};
    @(posedge clk);
    req <= '0;
    #1;
    r = rdata;
    chk32({31'h0, ack}, 32'h1);
  endtask
  // Configure with edges masked, fire one pulse, count edges to the start pulse
  task automatic run(input logic [31:0] c, f, i, input logic [3:0] m,
                     input logic e, id, input int x);
    int n;
    int got;
    @(posedge clk);
    en <= 1'b0;
    idle <= id;
    acc(`CTD_CTL_ADDR, 1'b1, c);
    acc(`CTD_FINE_ADDR, 1'b1, f);
    acc(`CTD_INP_ADDR, 1'b1, i);
    repeat (4) @(posedge clk);
    en <= e;
    mode <= m;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    got = 0;
    for (n = 0; n < ((x > 0) ? x + 20 : 60); n++) begin
      @(posedge clk);
      // Freeze window stretches the delay by exactly hold cycles
      ce <= !(n >= 6 && n < 6 + hold);
      #1;
      if (n == 4) chk32({31'h0, busy}, {31'h0, x > 5});
      if (start === 1'b1) begin
        got = n + 1;
        break;
      end
    end
    chkn(got, x);
    @(posedge clk);
    #1;
    chk32({31'h0, start}, 32'h0);
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    finish_test();
  end
  initial begin
    v = $urandom(38720);
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    acc(`CTD_CAP_ADDR, 1'b0, 32'h0);
    chk32(r, 32'hfff000b3);
    acc(`CTD_CTL_ADDR, 1'b0, 32'h0);
    chk32(r, 32'h00000001);
    acc(`CTD_INP_ADDR, 1'b0, 32'h0);
    chk32(r, 32'h00001001);
    acc(`CTD_FINE_ADDR, 1'b0, 32'h0);
    chk32(r, 32'h00000001);
    acc(32'hf1000304, 1'b0, 32'h0);
    chk32(r, 32'h0);
    chk32({31'h0, flag}, 32'h1);
    w = $urandom();
    acc(`CTD_CTL_ADDR, 1'b1, w);
    acc(`CTD_CTL_ADDR, 1'b0, 32'h0);
    chk32(r, (w & 32'hfff00042) | 32'h1);
    w = $urandom();
    acc(`CTD_INP_ADDR, 1'b1, w);
    @(posedge clk);
    idle <= 1'b1;
    acc(`CTD_INP_ADDR, 1'b0, 32'h0);
    chk32(r, (w & 32'h0000f880) | 32'h80000001);
    acc(`CTD_CAP_ADDR, 1'b1, w);
    acc(`CTD_CAP_ADDR, 1'b0, 32'h0);
    chk32(r, 32'hfff000b3);
    w = $urandom();
    acc(`CTD_FINE_ADDR, 1'b1, w);
    acc(`CTD_FINE_ADDR, 1'b0, 32'h0);
    chk32(r, (w & 32'hfffff840) | 32'h1);
    run(0, 0, 32'h1000, 0, 1, 0, 2);
    v = $urandom_range(3, 1);
    run({v[11:0], 20'h40}, 0, 32'h1000, 0, 1, 0, v * 20 + 3);
    v = $urandom_range(3, 1);
    @(posedge clk);
    abs_us <= v[21:0];
    run(32'hfff00042, 0, 32'h1000, 0, 1, 0, v * 20 + 3);
    v = $urandom_range(3, 1);
    run(0, {v[20:0], 11'h40}, 32'h1000, 0, 1, 0, v * 20 + 3);
    run(0, {21'h2, 11'h40}, 32'h1000, 4'h1, 1, 0, 2);
    run({12'h3, 20'h40}, {21'h1, 11'h40}, 32'h1000, 0, 1, 0, 23);
    hold = 5;
    run(0, {21'h1, 11'h40}, 32'h1000, 0, 1, 0, 28);
    hold = 0;
    run(0, 0, 32'h1000, 0, 0, 0, 0);
    run(0, 0, 32'h0000, 0, 1, 0, 0);
    run(0, 0, 32'h1080, 0, 1, 1, 2);
    finish_test();
  end
endmodule
